// ==== inc/fsq_pkg.sv ====
package fsq_pkg;

   // ---------------------------------------------
   // Command codes
   // ---------------------------------------------
   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] SECTOR_ERASE_3BYTE_CMD = 8'h20;
   localparam logic [7:0] SECTOR_ERASE_4BYTE_CMD = 8'h21;
   localparam logic [7:0] BLOCK_ERASE_3BYTE_CMD = 8'hD8;
   localparam logic [7:0] BLOCK_ERASE_4BYTE_CMD = 8'hDC;
   localparam logic [7:0] CHIP_ERASE_CMD = 8'h60;
   localparam logic [7:0] CHIP_ERASE_ALT_CMD = 8'hC7;
   localparam logic [7:0] PAGE_WRITE_3BYTE_CMD = 8'h02;
   localparam logic [7:0] PAGE_WRITE_4BYTE_CMD = 8'h12;
   localparam logic [7:0] LOW_POWER_ENTER_CMD = 8'hB9;
   localparam logic [7:0] LOW_POWER_RELEASE_CMD = 8'hAB;
   localparam logic [7:0] SOFT_RESET_CMD = 8'h99;

   // ---------------------------------------------
   // Array geometry and timing
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam logic [31:0] SECTOR_MASK = 32'hFFFF_F000;
   localparam logic [31:0] BLOCK_MASK = 32'hFFFF_0000;
   localparam int BLOCK_SHIFT = 16;
   localparam logic [31:0] TOTAL_BLOCKS = 32'h0000_0800;
   localparam logic [3:0] BP_ALL_LEVEL = 4'hC;
   localparam int PAGE_BYTES = 256;

   // Erase extent reported to the array
   localparam logic [1:0] ERASE_SECTOR = 2'h0;
   localparam logic [1:0] ERASE_BLOCK = 2'h1;
   localparam logic [1:0] ERASE_CHIP = 2'h2;

   // Sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ERASE = 5'h02,
      ST_PROG = 5'h04,
      ST_PD_WAIT = 5'h08,
      ST_PD = 5'h10
   } fsq_state_t;

endpackage : fsq_pkg

// ==== logic/fsq_pin_sync.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Pin synchroniser and edge finder
// ---------------------------------------------
module fsq_pin_sync
   import fsq_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic [7:0] io_in,
   output logic sclk_out,
   output logic sclk_rise_out,
   output logic sclk_fall_out,
   output logic cs_n_out,
   output logic cs_rise_out,
   output logic cs_fall_out,
   output logic [7:0] io_out
);

   logic [9:0] meta_reg;
   logic [9:0] sync_reg;
   logic sclk_d_reg;
   logic cs_d_reg;

   // Two stages; only the second stage is looked at
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         meta_reg <= 10'h200;
         sync_reg <= 10'h200;
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
      end
      else
      begin
         meta_reg <= {cs_n_in, sclk_in, io_in};
         sync_reg <= meta_reg;
         sclk_d_reg <= sync_reg[8];
         cs_d_reg <= sync_reg[9];
      end
   end

   // Edges from the second stage and its delayed copy
   assign sclk_out = sync_reg[8];
   assign cs_n_out = sync_reg[9];
   assign io_out = sync_reg[7:0];
   assign sclk_rise_out = sync_reg[8] & ~sclk_d_reg;
   assign sclk_fall_out = ~sync_reg[8] & sclk_d_reg;
   assign cs_rise_out = sync_reg[9] & ~cs_d_reg;
   assign cs_fall_out = ~sync_reg[9] & cs_d_reg;

endmodule : fsq_pin_sync

// ==== logic/fsq_sequencer.sv ====
`timescale 1ns/1ps
// How it works
// - Sector erase clears the whole 4K-byte sector that holds the address.
// - Addresses are four bytes for the 4-byte variants or in 4-byte or octal mode, else three.
// - Sector erase only runs if select rises right after the last address bit.
// - Sector erase sets busy, then clears busy and write-enable latch.
// - Sector erase of a block-protected region is not run.
// - Block erase clears the 64K-byte block; protected blocks are refused.
// - Block erase only runs if select rises right after the last address bit.
// - Block erase sets busy, then clears busy and write-enable latch.
// - Chip erase clears everything, busy during the cycle, latch cleared after.
// - Chip erase only runs if select rises right after the command byte.
// - Chip erase only runs when all four protect bits are zero.
// - Page write only clears bits; the last 256 bytes sent win.
// - Data past the page end wraps to the page start.
// - Up to 256 bytes land from the start offset; other bytes untouched.
// - Select must rise on a byte boundary, with clock low in double rate.
// - Page write sets busy, clears busy and latch; protected pages are skipped.
// - Power-down ignores all but release and software reset.
// - Power-down needs an exact one-byte frame and takes effect after a delay.
module fsq_sequencer
   import fsq_pkg::*;
#(
   parameter int SECTOR_ERASE_TIME_US = 100,
   parameter int BLOCK_ERASE_TIME_US = 200,
   parameter int ARRAY_ERASE_TIME_US = 400,
   parameter int PAGE_WRITE_TIME_US = 50,
   parameter int POWER_DOWN_ENTRY_DELAY_NS = 3000
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic [7:0] io_in,
   input wire logic octal_single_rate_mode_in,
   input wire logic octal_double_rate_mode_in,
   input wire logic addr_4byte_mode_in,
   input wire logic [3:0] block_protect_bits_in,
   output logic write_in_progress_flag_out,
   output logic write_enable_latch_out,
   output logic low_power_out,
   output logic erase_go_out,
   output logic [1:0] erase_kind_out,
   output logic [31:0] erase_base_out,
   output logic array_wr_out,
   output logic [31:0] array_addr_out,
   output logic [7:0] array_data_out
);

   // ---------------------------------------------
   // Cycle counts
   // ---------------------------------------------
   // Least times, so every count rounds up
   localparam int SE_CYC = (SECTOR_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BE_CYC = (BLOCK_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CE_CYC = (ARRAY_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PP_CYC = (PAGE_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PD_CYC = (POWER_DOWN_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Address byte count for a command
   function automatic logic [2:0] addr_len(input logic [7:0] cmd, input logic wide);
      logic [2:0] n;
      begin
         n = 3'h0;
         case (cmd)
            SECTOR_ERASE_3BYTE_CMD, BLOCK_ERASE_3BYTE_CMD, PAGE_WRITE_3BYTE_CMD:
               n = wide ? 3'h4 : 3'h3;
            SECTOR_ERASE_4BYTE_CMD, BLOCK_ERASE_4BYTE_CMD, PAGE_WRITE_4BYTE_CMD:
               n = 3'h4;
            default:
               n = 3'h0;
         endcase
         return n;
      end
   endfunction : addr_len

   // Top blocks protected, doubling per protect level
   function automatic logic is_protected(input logic [31:0] a, input logic [3:0] bp);
      logic [31:0] span;
      logic [31:0] blk;
      begin
         span = 32'h1 << (bp - 4'h1);
         blk = a >> BLOCK_SHIFT;
         if (bp == 4'h0)
            return 1'b0;
         else if (bp >= BP_ALL_LEVEL)
            return 1'b1;
         else
            return blk >= (TOTAL_BLOCKS - span);
      end
   endfunction : is_protected

   // ---------------------------------------------
   // Pin sampling
   // ---------------------------------------------
   logic sclk_s;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_n_s;
   logic cs_rise;
   logic cs_fall;
   logic [7:0] io_s;

   fsq_pin_sync u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .sclk_in(sclk_in),
      .cs_n_in(cs_n_in),
      .io_in(io_in),
      .sclk_out(sclk_s),
      .sclk_rise_out(sclk_rise),
      .sclk_fall_out(sclk_fall),
      .cs_n_out(cs_n_s),
      .cs_rise_out(cs_rise),
      .cs_fall_out(cs_fall),
      .io_out(io_s)
   );

   // ---------------------------------------------
   // Byte assembly
   // ---------------------------------------------
   fsq_state_t state_reg;
   logic octal;
   logic sample;
   logic byte_done;
   logic [7:0] byte_val;
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic [15:0] byte_cnt_reg;
   logic [7:0] cmd_reg;
   logic [31:0] addr_reg;
   logic [2:0] an;
   logic [7:0] wr_ptr_reg;
   logic [PAGE_BYTES-1:0] valid_reg;
   logic [7:0] page_mem [PAGE_BYTES];

   // Double rate takes a byte on both edges
   assign octal = octal_single_rate_mode_in | octal_double_rate_mode_in;
   assign sample = ~cs_n_s & (sclk_rise | (octal_double_rate_mode_in & sclk_fall));
   assign byte_done = sample & (octal | (bit_cnt_reg == 3'h7));
   assign byte_val = octal ? io_s : {shift_reg, io_s[0]};
   assign an = addr_len(cmd_reg, addr_4byte_mode_in | octal);

   // Bit and byte counters, cleared per frame
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         bit_cnt_reg <= 3'h0;
         shift_reg <= 7'h00;
         byte_cnt_reg <= 16'h0000;
      end
      else if (cs_fall)
      begin
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 16'h0000;
      end
      else if (sample)
      begin
         shift_reg <= byte_val[6:0];
         bit_cnt_reg <= octal ? 3'h0 : bit_cnt_reg + 3'h1;
         // Saturate so very long streams stay counted as long
         if (byte_done && byte_cnt_reg != 16'hFFFF)
            byte_cnt_reg <= byte_cnt_reg + 16'h0001;
      end
   end

   // Command and address capture
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cmd_reg <= 8'h00;
         addr_reg <= 32'h0000_0000;
      end
      else if (cs_fall)
         addr_reg <= 32'h0000_0000;
      else if (byte_done)
      begin
         if (byte_cnt_reg == 16'h0000)
            cmd_reg <= byte_val;
         else if (byte_cnt_reg <= 16'(an))
            addr_reg <= {addr_reg[23:0], byte_val};
      end
   end

   // ---------------------------------------------
   // Page buffer
   // ---------------------------------------------
   // Buffer is frozen while busy so the cycle in flight is safe
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_ptr_reg <= 8'h00;
         valid_reg <= '0;
      end
      else if (state_reg == ST_IDLE)
      begin
         if (cs_fall)
            valid_reg <= '0;
         else if (byte_done && an != 3'h0)
         begin
            if (byte_cnt_reg == 16'(an))
               wr_ptr_reg <= byte_val;
            else if (byte_cnt_reg > 16'(an))
            begin
               wr_ptr_reg <= wr_ptr_reg + 8'h01;
               valid_reg[wr_ptr_reg] <= 1'b1;
            end
         end
      end
   end

   // Data storage, written only with the pointer above
   always_ff @(posedge clk_in)
   begin
      if (state_reg == ST_IDLE && byte_done && an != 3'h0 && byte_cnt_reg > 16'(an))
         page_mem[wr_ptr_reg] <= byte_val;
   end

   // ---------------------------------------------
   // Frame end decisions
   // ---------------------------------------------
   logic complete;
   logic exact_cmd;
   logic exact_addr;
   logic [15:0] data_cnt;
   logic prog_ok;
   logic is_se;
   logic is_be;
   logic is_ce;
   logic is_pp;
   logic wel_reg;
   logic start_se;
   logic start_be;
   logic start_ce;
   logic start_pp;
   logic start_pd;
   logic set_wel;
   logic release_pd;

   assign is_se = (cmd_reg == SECTOR_ERASE_3BYTE_CMD) | (cmd_reg == SECTOR_ERASE_4BYTE_CMD);
   assign is_be = (cmd_reg == BLOCK_ERASE_3BYTE_CMD) | (cmd_reg == BLOCK_ERASE_4BYTE_CMD);
   assign is_ce = (cmd_reg == CHIP_ERASE_CMD) | (cmd_reg == CHIP_ERASE_ALT_CMD);
   assign is_pp = (cmd_reg == PAGE_WRITE_3BYTE_CMD) | (cmd_reg == PAGE_WRITE_4BYTE_CMD);
   // byte boundary, and clock low in double rate
   assign complete = cs_rise & (bit_cnt_reg == 3'h0) & ~(octal_double_rate_mode_in & sclk_s);
   assign exact_cmd = complete & (byte_cnt_reg == 16'h0001);
   assign exact_addr = complete & (byte_cnt_reg == 16'(an) + 16'h0001);
   assign data_cnt = byte_cnt_reg - 16'(an) - 16'h0001;
   // minimum data and even count in double rate
   assign prog_ok = (byte_cnt_reg > 16'(an)) & (data_cnt != 16'h0000)
                  & ~(octal_double_rate_mode_in & (data_cnt[0] | addr_reg[0]));

   // Only an idle sequencer takes a command, or a powered-down one a release; a busy one ignores the frame
   always_comb
   begin
      start_se = 1'b0;
      start_be = 1'b0;
      start_ce = 1'b0;
      start_pp = 1'b0;
      start_pd = 1'b0;
      set_wel = 1'b0;
      release_pd = 1'b0;
      if (state_reg == ST_IDLE)
      begin
         set_wel = exact_cmd & (cmd_reg == WRITE_ENABLE_CMD);
         // latch gates erase; protected sector refused
         start_se = exact_addr & is_se & wel_reg & ~is_protected(addr_reg, block_protect_bits_in);
         start_be = exact_addr & is_be & wel_reg & ~is_protected(addr_reg, block_protect_bits_in);
         // command byte only; no protect bits
         start_ce = exact_cmd & is_ce & wel_reg & (block_protect_bits_in == 4'h0);
         start_pp = complete & is_pp & prog_ok & wel_reg & ~is_protected(addr_reg, block_protect_bits_in);
         start_pd = exact_cmd & (cmd_reg == LOW_POWER_ENTER_CMD);
      end
      else if (state_reg == ST_PD)
         // only release or reset act here
         release_pd = exact_cmd & ((cmd_reg == LOW_POWER_RELEASE_CMD) | (cmd_reg == SOFT_RESET_CMD));
   end

   // ---------------------------------------------
   // Write-enable latch
   // ---------------------------------------------
   logic done;

   // rejected frames leave the latch alone
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         wel_reg <= 1'b0;
      else if (set_wel)
         wel_reg <= 1'b1;
      else if (done)
         wel_reg <= 1'b0;
      else if (state_reg == ST_IDLE && exact_cmd && cmd_reg == SOFT_RESET_CMD)
         wel_reg <= 1'b0;
   end

   assign write_enable_latch_out = wel_reg;

   // ---------------------------------------------
   // Sequencer and timer
   // ---------------------------------------------
   logic [31:0] timer_reg;
   logic wip_reg;
   logic pd_reg;

   assign done = (timer_reg == 32'h0000_0001) & ((state_reg == ST_ERASE) | (state_reg == ST_PROG));

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_reg <= ST_IDLE;
         timer_reg <= 32'h0000_0000;
         wip_reg <= 1'b0;
         pd_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (start_se || start_be || start_ce)
               begin
                  state_reg <= ST_ERASE;
                  wip_reg <= 1'b1;
                  timer_reg <= start_se ? 32'(SE_CYC) : (start_be ? 32'(BE_CYC) : 32'(CE_CYC));
               end
               else if (start_pp)
               begin
                  state_reg <= ST_PROG;
                  wip_reg <= 1'b1;
                  // Walk of the page needs its full length at least
                  timer_reg <= (PP_CYC > PAGE_BYTES) ? 32'(PP_CYC) : 32'(PAGE_BYTES + 1);
               end
               else if (start_pd)
               begin
                  state_reg <= ST_PD_WAIT;
                  timer_reg <= 32'(PD_CYC);
               end
            end
            ST_ERASE, ST_PROG:
            begin
               timer_reg <= timer_reg - 32'h0000_0001;
               if (done)
               begin
                  state_reg <= ST_IDLE;
                  wip_reg <= 1'b0;
               end
            end
            ST_PD_WAIT:
            begin
               // low power only after the entry delay
               timer_reg <= timer_reg - 32'h0000_0001;
               if (timer_reg == 32'h0000_0001)
               begin
                  state_reg <= ST_PD;
                  pd_reg <= 1'b1;
               end
            end
            ST_PD:
            begin
               if (release_pd)
               begin
                  state_reg <= ST_IDLE;
                  pd_reg <= 1'b0;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               wip_reg <= 1'b0;
               pd_reg <= 1'b0;
            end
         endcase
      end
   end

   assign write_in_progress_flag_out = wip_reg;
   assign low_power_out = pd_reg;

   // ---------------------------------------------
   // Array side
   // ---------------------------------------------
   logic [8:0] walk_reg;
   logic [23:0] page_reg;

   // Erase request, one pulse at cycle start
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         erase_go_out <= 1'b0;
         erase_kind_out <= ERASE_SECTOR;
         erase_base_out <= 32'h0000_0000;
      end
      else
      begin
         erase_go_out <= start_se | start_be | start_ce;
         if (start_se)
         begin
            erase_kind_out <= ERASE_SECTOR;
            erase_base_out <= addr_reg & SECTOR_MASK;
         end
         else if (start_be)
         begin
            erase_kind_out <= ERASE_BLOCK;
            erase_base_out <= addr_reg & BLOCK_MASK;
         end
         else if (start_ce)
         begin
            erase_kind_out <= ERASE_CHIP;
            erase_base_out <= 32'h0000_0000;
         end
      end
   end

   // Page walk: one write per filled page position, untouched bytes skipped
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         walk_reg <= 9'h100;
         page_reg <= 24'h00_0000;
         array_wr_out <= 1'b0;
         array_addr_out <= 32'h0000_0000;
         array_data_out <= 8'hFF;
      end
      else
      begin
         array_wr_out <= 1'b0;
         if (start_pp)
         begin
            walk_reg <= 9'h000;
            page_reg <= addr_reg[31:8];
         end
         else if (state_reg == ST_PROG && !walk_reg[8])
         begin
            walk_reg <= walk_reg + 9'h001;
            if (valid_reg[walk_reg[7:0]])
            begin
               // array ANDs this in, so bits only go to zero
               array_wr_out <= 1'b1;
               array_addr_out <= {page_reg, walk_reg[7:0]};
               array_data_out <= page_mem[walk_reg[7:0]];
            end
         end
      end
   end

endmodule : fsq_sequencer

// ==== dv/fsq_sequencer_assertions.sv ====
`timescale 1ns/1ps
// ----
// Port checker for the sequencer
// ----
module fsq_sequencer_assertions
   import fsq_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic [3:0] block_protect_bits_in,
   input wire logic write_in_progress_flag_out,
   input wire logic write_enable_latch_out,
   input wire logic low_power_out,
   input wire logic erase_go_out,
   input wire logic [1:0] erase_kind_out,
   input wire logic [31:0] erase_base_out,
   input wire logic array_wr_out,
   input wire logic [31:0] array_addr_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic prev_wr_reg;
   logic [31:0] prev_addr_reg;

   // Previous write, for page order checks
   always_ff @(posedge clk_in)
   begin
      prev_wr_reg <= rst_in ? 1'b0 : array_wr_out;
      prev_addr_reg <= array_addr_out;
   end

   property p_go_wel; erase_go_out |-> write_enable_latch_out; endproperty
   property p_go_pulse; erase_go_out |=> !erase_go_out; endproperty
   property p_go_busy; erase_go_out |-> ##[0:2] write_in_progress_flag_out; endproperty
   property p_sector; erase_go_out && erase_kind_out == ERASE_SECTOR |-> erase_base_out[11:0] == 12'h000;
   endproperty
   property p_block; erase_go_out && erase_kind_out == ERASE_BLOCK |-> erase_base_out[15:0] == 16'h0000;
   endproperty
   property p_chip; erase_go_out && erase_kind_out == ERASE_CHIP |-> block_protect_bits_in == 4'h0;
   endproperty
   property p_end; $fell(write_in_progress_flag_out) |-> !write_enable_latch_out; endproperty
   // Busy starts only once select is back high
   property p_cs; $rose(write_in_progress_flag_out) |-> cs_n_in; endproperty
   property p_wr; array_wr_out |-> write_in_progress_flag_out; endproperty
   // Back-to-back writes stay in one page, rising
   property p_page; array_wr_out && prev_wr_reg |-> array_addr_out[31:8] == prev_addr_reg[31:8]
      && array_addr_out[7:0] > prev_addr_reg[7:0]; endproperty
   property p_pd; low_power_out |-> !write_in_progress_flag_out && !erase_go_out; endproperty

   a_go_wel: assert property (p_go_wel) else $error("erase without latch");
   a_go_pulse: assert property (p_go_pulse) else $error("erase start too long");
   a_go_busy: assert property (p_go_busy) else $error("erase without busy");
   a_sector: assert property (p_sector) else $error("sector base unaligned");
   a_block: assert property (p_block) else $error("block base unaligned");
   a_chip: assert property (p_chip) else $error("chip erase while protected");
   a_end: assert property (p_end) else $error("latch kept after cycle");
   a_cs: assert property (p_cs) else $error("busy before select high");
   a_wr: assert property (p_wr) else $error("write outside busy");
   a_page: assert property (p_page) else $error("write order left page");
   a_pd: assert property (p_pd) else $error("activity in power-down");

   c_chip: cover property (erase_go_out && erase_kind_out == ERASE_CHIP);
   c_burst: cover property (array_wr_out && prev_wr_reg);
   c_pd: cover property ($rose(low_power_out));
endmodule : fsq_sequencer_assertions

// ==== dv/fsq_host_model.sv ====
`timescale 1ns/1ps
// ----
// Host controller on the serial pins
// ----
module fsq_host_model (
   input wire logic clk_in,
   input wire logic oct_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic [7:0] io_out
);
   // Idle bus: clock parked low, select high
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      io_out = 8'hA5;
   end

   // Whole bytes, then extra bits break the boundary
   task automatic frame(input logic [7:0] q[$], input int ex);
      int n;
      @(posedge clk_in) cs_n_out <= 1'b0;
      // Octal single rate: one byte per clock; double rate is never driven
      n = q.size() * (oct_in ? 1 : 8);
      for (int i = 0; i < n + ex; i++)
      begin
         if (oct_in)
            io_out <= (i < n) ? q[i] : 8'hFF;
         else
            io_out[0] <= (i < n) ? q[i / 8][7 - i % 8] : 1'b1;
         repeat (4) @(posedge clk_in);
         sclk_out <= 1'b1;
         repeat (4) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      // Released lines do not keep the last level
      io_out <= ~io_out;
      repeat (16) @(posedge clk_in);
   endtask : frame
endmodule : fsq_host_model

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import fsq_pkg::*;
   logic clk_in, rst_in, sclk, cs_n, write_in_progress_flag, write_enable_latch, lp, go, awr, os = 1'b0, od = 1'b0, a4 = 1'b0;
   logic [3:0] bp;
   logic [7:0] io, adata;
   logic [1:0] kind;
   logic [31:0] base, aaddr, a;
   logic [15:0] seed = 16'hF64E;
   logic [33:0] go_q[$];
   logic [39:0] wr_q[$];
   logic [7:0] cmds[4] = '{SECTOR_ERASE_3BYTE_CMD, SECTOR_ERASE_4BYTE_CMD, BLOCK_ERASE_3BYTE_CMD,
      BLOCK_ERASE_4BYTE_CMD};
   logic [7:0] q[$];
   int err_total = 0, n_compared = 0;

   fsq_sequencer #(.SECTOR_ERASE_TIME_US(1), .BLOCK_ERASE_TIME_US(1), .ARRAY_ERASE_TIME_US(1),
      .POWER_DOWN_ENTRY_DELAY_NS(100)) uut (.clk_in(clk_in), .rst_in(rst_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io), .octal_single_rate_mode_in(os),
      .octal_double_rate_mode_in(od), .addr_4byte_mode_in(a4), .block_protect_bits_in(bp),
      .write_in_progress_flag_out(write_in_progress_flag), .write_enable_latch_out(write_enable_latch), .low_power_out(lp),
      .erase_go_out(go), .erase_kind_out(kind), .erase_base_out(base), .array_wr_out(awr),
      .array_addr_out(aaddr), .array_data_out(adata));
   fsq_host_model host (.clk_in(clk_in), .oct_in(os), .sclk_out(sclk), .cs_n_out(cs_n), .io_out(io));

   // Free-running 40 MHz clock
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // Collect erase starts and array writes
   always @(posedge clk_in)
   begin
      if (go === 1'b1) go_q.push_back({kind, base});
      if (awr === 1'b1) wr_q.push_back({aaddr, adata});
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
      n_compared++;
      if (exp !== got)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Latch set before every frame; wait for any cycle to finish
   task automatic run(input logic [7:0] f[$], input int ex, input logic exp_wel);
      go_q.delete();
      wr_q.delete();
      host.frame('{WRITE_ENABLE_CMD}, 0);
      host.frame(f, ex);
      for (int i = 0; i < 20000 && write_in_progress_flag !== 1'b0; i++) @(posedge clk_in);
      chk("latch", exp_wel, write_enable_latch);
   endtask : run

   task automatic chk_go(input int n, input logic [33:0] rec);
      chk("erase count", n, go_q.size());
      if (n > 0) chk("erase record", rec, go_q[0]);
   endtask : chk_go

   // Page write of n >= 1 bytes; expected writes in page order, later bytes winning
   task automatic prog(input logic [31:0] st, input int n, input int ex, input logic ok);
      logic [7:0] pg[256];
      bit hit[256];
      logic [7:0] j;
      int k;
      q = '{PAGE_WRITE_3BYTE_CMD, st[23:16], st[15:8], st[7:0]};
      k = 0;
      for (int i = 0; i < n; i++)
      begin
         seed = lfsr(seed);
         q.push_back(seed[7:0]);
         j = st[7:0] + i[7:0];
         pg[j] = seed[7:0];
         hit[j] = 1'b1;
      end
      run(q, ex, !ok);
      for (int i = 0; i < 256; i++)
      begin
         if (ok && hit[i])
         begin
            chk("array write", {st[31:8], i[7:0], pg[i]}, wr_q[k]);
            k++;
         end
      end
      chk("write count", k, wr_q.size());
   endtask : prog

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial
   begin
      rst_in = 1'b1;
      bp = 4'h0;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk("reset state", {3'b000, 8'hFF}, {write_in_progress_flag, write_enable_latch, lp, adata});
      host.frame('{SECTOR_ERASE_3BYTE_CMD, 8'h01, 8'h23, 8'h45}, 0);
      chk("erase without latch", 0, go_q.size());
      for (int c = 0; c < 4; c++)
      begin
         seed = lfsr(seed);
         a = {5'h00, c[0] ? seed[2:0] : 3'h0, seed, seed[15:8]};
         q = '{cmds[c], a[31:24], a[23:16], a[15:8], a[7:0]};
         if (!c[0]) q.delete(1);
         run(q, 0, 1'b0);
         chk_go(1, c > 1 ? {ERASE_BLOCK, a & BLOCK_MASK} : {ERASE_SECTOR, a & SECTOR_MASK});
         run(q, 1, 1'b1);
         chk_go(0, 0);
      end
      bp <= 4'h1;
      run('{SECTOR_ERASE_4BYTE_CMD, 8'h07, 8'hFF, 8'h10, 8'h00}, 0, 1'b1);
      chk_go(0, 0);
      run('{BLOCK_ERASE_4BYTE_CMD, 8'h07, 8'hFF, 8'h10, 8'h00}, 0, 1'b1);
      chk_go(0, 0);
      run('{CHIP_ERASE_CMD}, 0, 1'b1);
      chk_go(0, 0);
      run('{BLOCK_ERASE_4BYTE_CMD, 8'h07, 8'hFE, 8'h12, 8'h34}, 0, 1'b0);
      chk_go(1, {ERASE_BLOCK, 32'h07FE_0000});
      bp <= 4'h0;
      run('{CHIP_ERASE_CMD}, 1, 1'b1);
      chk_go(0, 0);
      run('{CHIP_ERASE_ALT_CMD}, 0, 1'b0);
      chk_go(1, {ERASE_CHIP, 32'h0});
      a4 <= 1'b1;
      run('{SECTOR_ERASE_3BYTE_CMD, 8'h01, 8'h23, 8'h45, 8'h67}, 0, 1'b0);
      chk_go(1, {ERASE_SECTOR, 32'h0123_4000});
      {a4, os} <= 2'b01;
      run('{BLOCK_ERASE_3BYTE_CMD, 8'h00, 8'h05, 8'h67, 8'h89}, 0, 1'b0);
      chk_go(1, {ERASE_BLOCK, 32'h0005_0000});
      os <= 1'b0;
      prog(32'h0012_34FE, 3, 0, 1'b1);
      prog(32'h0012_3500, 258, 0, 1'b1);
      prog(32'h0012_3640, 2, 3, 1'b0);
      run('{LOW_POWER_ENTER_CMD}, 2, 1'b1);
      chk("power-down on bad frame", 0, lp);
      run('{LOW_POWER_ENTER_CMD}, 0, 1'b1);
      chk("power-down", 1, lp);
      run('{SECTOR_ERASE_3BYTE_CMD, 8'h00, 8'h10, 8'h00}, 0, 1'b1);
      chk_go(0, 0);
      host.frame('{LOW_POWER_RELEASE_CMD}, 0);
      chk("release", 0, lp);
      report_and_stop();
   end

   // Watchdog, well past the expected run length
   initial
   begin
      #1500000;
      err_total++;
      report_and_stop();
   end
endmodule : testbench

bind fsq_sequencer fsq_sequencer_assertions u_chk (.clk_in, .rst_in, .cs_n_in, .block_protect_bits_in,
   .write_in_progress_flag_out, .write_enable_latch_out, .low_power_out, .erase_go_out, .erase_kind_out,
   .erase_base_out, .array_wr_out, .array_addr_out);
